// *** rtl/cgs_pkg.sv ***
// constants for the can global status, error flag and error counter block
package cgs_pkg;

	// register addresses in the special function register space
	localparam logic [7:0] ADDR_GENERAL_INTERRUPT_FLAGS  = 8'h9B;
	localparam logic [7:0] ADDR_TRANSMIT_ERROR_COUNT     = 8'h9C;
	localparam logic [7:0] ADDR_RECEIVE_ERROR_COUNT      = 8'h9D;
	localparam logic [7:0] ADDR_GENERAL_STATUS           = 8'hAA;
	localparam logic [7:0] ADDR_GENERAL_INTERRUPT_ENABLE = 8'hC1;

	// general status bit positions
	localparam int STA_OVERLOAD_BIT = 6;
	localparam int STA_TX_BUSY_BIT  = 4;
	localparam int STA_RX_BUSY_BIT  = 3;
	localparam int STA_ENABLED_BIT  = 2;
	localparam int STA_BUS_OFF_BIT  = 1;
	localparam int STA_PASSIVE_BIT  = 0;

	// general interrupt flag bit positions
	localparam int GIT_ANY_IRQ_BIT  = 7;
	localparam int GIT_TIMER_BIT    = 5;
	localparam int GIT_BUFFER_BIT   = 4;
	localparam int GIT_STUFF_BIT    = 3;
	localparam int GIT_CRC_BIT      = 2;
	localparam int GIT_FORM_BIT     = 1;
	localparam int GIT_ACK_BIT      = 0;
	localparam int GIT_FLAG_COUNT   = 6;

	// general interrupt enable field: bits 5..1
	localparam int GIE_LSB          = 1;
	localparam int GIE_WIDTH        = 5;
	localparam int GIE_RX_IDX       = 4;
	localparam int GIE_TX_IDX       = 3;
	localparam int GIE_OBJ_ERR_IDX  = 2;
	localparam int GIE_BUFFER_IDX   = 1;
	localparam int GIE_GEN_ERR_IDX  = 0;

	// reset values
	localparam logic [5:0] GIT_FLAGS_RESET = 6'h00;
	localparam logic [4:0] GIE_RESET       = 5'h00;
	localparam logic [7:0] BYTE_ZERO       = 8'h00;

	// timer wrap detection
	localparam logic [15:0] TIMER_MAX  = 16'hFFFF;
	localparam logic [15:0] TIMER_ZERO = 16'h0000;

	// controller start needs this many clock periods after the enable command
	localparam int ENABLE_DELAY_CYCLES = 2;

	// stuffing: a run longer than this many equal bits is an error
	localparam logic [2:0] STUFF_RUN_LIMIT = 3'h5;

	// can 2.0 crc-15 generator polynomial
	localparam logic [14:0] CRC15_POLY = 15'h4599;

	// fault confinement figures
	localparam logic [8:0] TEC_STEP_UP      = 9'h008;
	localparam logic [8:0] TEC_BUS_OFF      = 9'h100;
	localparam logic [8:0] TEC_PASSIVE      = 9'h080;
	localparam logic [7:0] REC_PASSIVE      = 8'h80;
	localparam logic [7:0] REC_MAX          = 8'hFF;
	localparam logic [7:0] REC_PASSIVE_BACK = 8'h7F;
	localparam logic [7:0] REC_STEP_BIG     = 8'h08;
	localparam logic [7:0] RECOVERY_SEQS    = 8'h80;

	// enable state of the controller
	typedef enum logic [1:0] {EN_OFF, EN_STARTING, EN_ON, EN_STOPPING} cgs_en_state_type;

endpackage

// *** rtl/cgs_crc15.sv ***
// crc-15 accumulator over destuffed received bits
`timescale 1ns/1ns
`default_nettype none

module cgs_crc15
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// bit stream
	input  wire logic        crc_init,
	input  wire logic        bit_valid,
	input  wire logic        bit_value,
	// result
	output logic      [14:0] crc_value
);

	logic feedback;

	// serial lfsr; init wins so a new frame never inherits old remainder
	assign feedback = bit_value ^ crc_value[14];

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			crc_value <= 15'h0000;
		else if (crc_init)
			crc_value <= 15'h0000;
		else if (bit_valid)
		begin
			if (feedback)
				crc_value <= {crc_value[13:0], 1'b0} ^ cgs_pkg::CRC15_POLY;
			else
				crc_value <= {crc_value[13:0], 1'b0};
		end
	end

endmodule

`default_nettype wire

// *** rtl/cgs_global_status.sv ***
// global status, error flags, interrupt image and error counters of the can controller
`timescale 1ns/1ns
`default_nettype none

module cgs_global_status
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// special function register access
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	// protocol engine activity
	input  wire logic        tx_frame_active,
	input  wire logic        tx_ack_active,
	input  wire logic        tx_frame_pending,
	input  wire logic        ifs_active,
	input  wire logic        overload_tx_active,
	input  wire logic        rx_frame_active,
	// enable command from general control
	input  wire logic        enable_cmd,
	// can timer and reception buffer
	input  wire logic [15:0] can_timer_value,
	input  wire logic        rx_buffer_full,
	input  wire logic        timer_overrun_irq_enable,
	// bit level checks
	input  wire logic        bit_strobe,
	input  wire logic        bit_value,
	input  wire logic        stuff_check_en,
	input  wire logic        crc_init,
	input  wire logic        crc_data_bit_valid,
	input  wire logic        crc_field_bit_valid,
	input  wire logic        crc_check,
	input  wire logic        fixed_form_check,
	input  wire logic        ack_slot_check,
	// fault confinement events
	input  wire logic        tec_inc,
	input  wire logic        tec_dec,
	input  wire logic        rec_inc_small,
	input  wire logic        rec_inc_big,
	input  wire logic        rec_dec,
	input  wire logic        recovery_seq_seen,
	// interrupt requests from message objects
	input  wire logic        rx_irq_req,
	input  wire logic        tx_irq_req,
	input  wire logic        object_error_irq_req,
	// outputs
	output logic             can_irq_request,
	output logic             bus_off_state,
	output logic             error_passive_state
);

	////////////////////////////////////////////////////////////////////////
	// declarations
	////////////////////////////////////////////////////////////////////////

	logic                    overload_frame_active_r;
	logic                    transmitter_busy_r;
	logic                    receiver_busy_r;
	logic                    controller_enabled_state_r;
	cgs_pkg::cgs_en_state_type en_state_r;
	logic [1:0]              en_count_r;
	logic [5:0]              gflag_r;
	logic [5:0]              gflag_set;
	logic [5:0]              gflag_clr;
	logic [4:0]              gie_r;
	logic [15:0]             timer_prev_r;
	logic                    buffer_full_prev_r;
	logic [2:0]              run_len_r;
	logic                    run_bit_r;
	logic                    stuff_err;
	logic [14:0]             crc_calc;
	logic [14:0]             crc_rx_r;
	logic [8:0]              tec_r;
	logic [7:0]              rec_r;
	logic [7:0]              recovery_cnt_r;
	logic [7:0]              transmit_error_count;
	logic [7:0]              receive_error_count;
	logic                    irq_any;
	logic [7:0]              read_nxt;
	logic                    wr_gflags;
	logic                    wr_gie;

	////////////////////////////////////////////////////////////////////////
	// activity status
	////////////////////////////////////////////////////////////////////////

	// busy flags are plain status; none of them feeds the interrupt image
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			overload_frame_active_r <= 1'b0;
			transmitter_busy_r      <= 1'b0;
			receiver_busy_r         <= 1'b0;
		end
		else
		begin
			overload_frame_active_r <= overload_tx_active;
			transmitter_busy_r      <= tx_frame_active | tx_ack_active
			                           | (ifs_active & tx_frame_pending);
			receiver_busy_r         <= rx_frame_active;
		end
	end

	// enable state: start takes fixed cycles, stop waits until the bus goes quiet
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			en_state_r                 <= cgs_pkg::EN_OFF;
			en_count_r                 <= 2'h0;
			controller_enabled_state_r <= 1'b0;
		end
		else
		begin
			case (en_state_r)
				cgs_pkg::EN_OFF:
				begin
					en_count_r <= 2'h0;
					if (enable_cmd)
						en_state_r <= cgs_pkg::EN_STARTING;
				end
				cgs_pkg::EN_STARTING:
				begin
					en_count_r <= en_count_r + 2'h1;
					if (!enable_cmd)
						en_state_r <= cgs_pkg::EN_OFF;
					else if (en_count_r == 2'(cgs_pkg::ENABLE_DELAY_CYCLES - 1))
					begin
						en_state_r                 <= cgs_pkg::EN_ON;
						controller_enabled_state_r <= 1'b1;
					end
				end
				cgs_pkg::EN_ON:
				begin
					if (!enable_cmd)
						en_state_r <= cgs_pkg::EN_STOPPING;
				end
				default:
				begin
					// the running frame ends normally before we report disabled
					if (enable_cmd)
						en_state_r <= cgs_pkg::EN_ON;
					else if (!tx_frame_active && !tx_ack_active && !rx_frame_active)
					begin
						en_state_r                 <= cgs_pkg::EN_OFF;
						controller_enabled_state_r <= 1'b0;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// error and event detection
	////////////////////////////////////////////////////////////////////////

	// history for edge and wrap detection
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			timer_prev_r       <= 16'h0000;
			buffer_full_prev_r <= 1'b0;
		end
		else
		begin
			timer_prev_r       <= can_timer_value;
			buffer_full_prev_r <= rx_buffer_full;
		end
	end

	// run length of equal bus bits; restarts whenever the check is off
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			run_len_r <= 3'h0;
			run_bit_r <= 1'b1;
		end
		else if (!stuff_check_en)
			run_len_r <= 3'h0;
		else if (bit_strobe)
		begin
			run_bit_r <= bit_value;
			if (run_len_r == 3'h0 || bit_value != run_bit_r)
				run_len_r <= 3'h1;
			else if (run_len_r <= cgs_pkg::STUFF_RUN_LIMIT)
				run_len_r <= run_len_r + 3'h1;
		end
	end

	// sixth equal bit in a row is the first one beyond the limit
	assign stuff_err = stuff_check_en & bit_strobe & (run_len_r == cgs_pkg::STUFF_RUN_LIMIT)
	                   & (bit_value == run_bit_r);

	// crc over sof..data; the received crc field is shifted in beside it
	cgs_crc15 u_crc
	(
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.crc_init  (crc_init),
		.bit_valid (crc_data_bit_valid),
		.bit_value (bit_value),
		.crc_value (crc_calc)
	);

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			crc_rx_r <= 15'h0000;
		else if (crc_init)
			crc_rx_r <= 15'h0000;
		else if (crc_field_bit_valid)
			crc_rx_r <= {crc_rx_r[13:0], bit_value};
	end

	// set sources, one per flag
	always_comb
	begin
		gflag_set                         = 6'h00;
		gflag_set[cgs_pkg::GIT_TIMER_BIT] = (timer_prev_r == cgs_pkg::TIMER_MAX)
		                                    && (can_timer_value == cgs_pkg::TIMER_ZERO);
		gflag_set[cgs_pkg::GIT_BUFFER_BIT] = rx_buffer_full & ~buffer_full_prev_r;
		gflag_set[cgs_pkg::GIT_STUFF_BIT]  = stuff_err;
		gflag_set[cgs_pkg::GIT_CRC_BIT]    = crc_check && (crc_calc != crc_rx_r);
		gflag_set[cgs_pkg::GIT_FORM_BIT]   = fixed_form_check & bit_strobe & ~bit_value;
		gflag_set[cgs_pkg::GIT_ACK_BIT]    = ack_slot_check & bit_strobe & bit_value;
	end

	////////////////////////////////////////////////////////////////////////
	// register writes
	////////////////////////////////////////////////////////////////////////

	assign wr_gflags = sfr_wr && (sfr_addr == cgs_pkg::ADDR_GENERAL_INTERRUPT_FLAGS);
	assign wr_gie    = sfr_wr && (sfr_addr == cgs_pkg::ADDR_GENERAL_INTERRUPT_ENABLE);

	// writing a zero clears a flag, writing a one leaves it alone
	assign gflag_clr = wr_gflags ? ~sfr_wdata[5:0] : 6'h00;

	// sticky flags; a set in the clearing cycle wins so no event is lost
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			gflag_r <= cgs_pkg::GIT_FLAGS_RESET;
		else
			gflag_r <= gflag_set | (gflag_r & ~gflag_clr);
	end

	// interrupt enables; reserved bits 7, 6 and 0 are not stored
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			gie_r <= cgs_pkg::GIE_RESET;
		else if (wr_gie)
			gie_r <= sfr_wdata[cgs_pkg::GIE_LSB +: cgs_pkg::GIE_WIDTH];
	end

	////////////////////////////////////////////////////////////////////////
	// fault confinement
	////////////////////////////////////////////////////////////////////////

	// counters freeze in bus-off; recovery after enough idle sequences resets them
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tec_r          <= 9'h000;
			rec_r          <= 8'h00;
			recovery_cnt_r <= 8'h00;
			bus_off_state  <= 1'b0;
		end
		else if (bus_off_state)
		begin
			if (recovery_seq_seen)
			begin
				if (recovery_cnt_r == cgs_pkg::RECOVERY_SEQS - 8'h01)
				begin
					bus_off_state  <= 1'b0;
					tec_r          <= 9'h000;
					rec_r          <= 8'h00;
					recovery_cnt_r <= 8'h00;
				end
				else
					recovery_cnt_r <= recovery_cnt_r + 8'h01;
			end
		end
		else
		begin
			// an error outweighs a success reported in the same cycle
			if (tec_inc)
			begin
				if (tec_r >= cgs_pkg::TEC_BUS_OFF - cgs_pkg::TEC_STEP_UP)
				begin
					tec_r         <= cgs_pkg::TEC_BUS_OFF;
					bus_off_state <= 1'b1;
				end
				else
					tec_r <= tec_r + cgs_pkg::TEC_STEP_UP;
			end
			else if (tec_dec && tec_r != 9'h000)
				tec_r <= tec_r - 9'h001;
			if (rec_inc_big)
				rec_r <= (rec_r > cgs_pkg::REC_MAX - cgs_pkg::REC_STEP_BIG)
				         ? cgs_pkg::REC_MAX : rec_r + cgs_pkg::REC_STEP_BIG;
			else if (rec_inc_small)
				rec_r <= (rec_r == cgs_pkg::REC_MAX) ? rec_r : rec_r + 8'h01;
			else if (rec_dec)
			begin
				if (rec_r >= cgs_pkg::REC_PASSIVE)
					rec_r <= cgs_pkg::REC_PASSIVE_BACK;
				else if (rec_r != 8'h00)
					rec_r <= rec_r - 8'h01;
			end
		end
	end

	// the nine-bit count only exceeds eight bits at bus-off; show it saturated
	assign transmit_error_count = tec_r[8] ? cgs_pkg::REC_MAX : tec_r[7:0];
	assign receive_error_count  = rec_r;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			error_passive_state <= 1'b0;
		else
			error_passive_state <= ~bus_off_state & ~(tec_inc & (tec_r >= cgs_pkg::TEC_BUS_OFF
			                       - cgs_pkg::TEC_STEP_UP)) & ((tec_r >= cgs_pkg::TEC_PASSIVE)
			                       || (rec_r >= cgs_pkg::REC_PASSIVE));
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt image
	////////////////////////////////////////////////////////////////////////

	// timer overrun is gated by the auxiliary enable, the rest by the general enables
	assign irq_any = (gflag_r[cgs_pkg::GIT_TIMER_BIT] & timer_overrun_irq_enable)
	                 | (rx_irq_req & gie_r[cgs_pkg::GIE_RX_IDX])
	                 | (tx_irq_req & gie_r[cgs_pkg::GIE_TX_IDX])
	                 | (object_error_irq_req & gie_r[cgs_pkg::GIE_OBJ_ERR_IDX])
	                 | (gflag_r[cgs_pkg::GIT_BUFFER_BIT] & gie_r[cgs_pkg::GIE_BUFFER_IDX])
	                 | (|gflag_r[cgs_pkg::GIT_STUFF_BIT:cgs_pkg::GIT_ACK_BIT]
	                    & gie_r[cgs_pkg::GIE_GEN_ERR_IDX]);

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			can_irq_request <= 1'b0;
		else
			can_irq_request <= irq_any;
	end

	////////////////////////////////////////////////////////////////////////
	// register reads
	////////////////////////////////////////////////////////////////////////

	// reserved bits read as zero; unmapped addresses read as zero
	always_comb
	begin
		read_nxt = cgs_pkg::BYTE_ZERO;
		if (sfr_addr == cgs_pkg::ADDR_GENERAL_INTERRUPT_FLAGS)
		begin
			read_nxt[5:0]                     = gflag_r;
			read_nxt[cgs_pkg::GIT_ANY_IRQ_BIT] = can_irq_request;
		end
		else if (sfr_addr == cgs_pkg::ADDR_TRANSMIT_ERROR_COUNT)
			read_nxt = transmit_error_count;
		else if (sfr_addr == cgs_pkg::ADDR_RECEIVE_ERROR_COUNT)
			read_nxt = receive_error_count;
		else if (sfr_addr == cgs_pkg::ADDR_GENERAL_STATUS)
		begin
			read_nxt[cgs_pkg::STA_OVERLOAD_BIT] = overload_frame_active_r;
			read_nxt[cgs_pkg::STA_TX_BUSY_BIT]  = transmitter_busy_r;
			read_nxt[cgs_pkg::STA_RX_BUSY_BIT]  = receiver_busy_r;
			read_nxt[cgs_pkg::STA_ENABLED_BIT]  = controller_enabled_state_r;
			read_nxt[cgs_pkg::STA_BUS_OFF_BIT]  = bus_off_state;
			read_nxt[cgs_pkg::STA_PASSIVE_BIT]  = error_passive_state;
		end
		else if (sfr_addr == cgs_pkg::ADDR_GENERAL_INTERRUPT_ENABLE)
			read_nxt[cgs_pkg::GIE_LSB +: cgs_pkg::GIE_WIDTH] = gie_r;
	end

	// read data is captured on the read strobe and held until the next one
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			sfr_rdata <= cgs_pkg::BYTE_ZERO;
		else if (sfr_rd)
			sfr_rdata <= read_nxt;
	end

endmodule

`default_nettype wire

// *** sim/cgs_properties.sv ***
// concurrent checks on the ports of the global status block
`timescale 1ns/1ns
`default_nettype none

module cgs_properties
(
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       resetn,
	// register access
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	// engine activity
	input wire logic       tx_frame_active,
	input wire logic       tx_ack_active,
	input wire logic       tx_frame_pending,
	input wire logic       ifs_active,
	input wire logic       overload_tx_active,
	input wire logic       rx_frame_active,
	// results
	input wire logic       can_irq_request,
	input wire logic       bus_off_state,
	input wire logic       error_passive_state
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	////////////////////////////////////////////////////////////////////////////
	// read decodes; status bits lag the engine by one register stage
	logic sta;
	logic git;
	logic unm;
	assign sta = sfr_rd && sfr_addr == 8'hAA;
	assign git = sfr_rd && sfr_addr == 8'h9B;
	assign unm = sfr_rd && !(sfr_addr inside {8'h9B, 8'h9C, 8'h9D, 8'hAA, 8'hC1});

	////////////////////////////////////////////////////////////////////////////
	property p_sta_tx;
		sta |=> sfr_rdata[4] == $past(tx_frame_active || tx_ack_active
			|| (tx_frame_pending && ifs_active), 2);
	endproperty
	a_sta_tx: assert property (p_sta_tx) else $error("tx busy bit wrong");
	property p_sta_rx;
		sta |=> sfr_rdata[3] == $past(rx_frame_active, 2);
	endproperty
	a_sta_rx: assert property (p_sta_rx) else $error("rx busy bit wrong");
	property p_sta_ovl;
		sta |=> sfr_rdata[6] == $past(overload_tx_active, 2) && !sfr_rdata[7] && !sfr_rdata[5];
	endproperty
	a_sta_ovl: assert property (p_sta_ovl) else $error("overload bit wrong");
	property p_unmapped;
		unm |=> sfr_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_git_rsv;
		git |=> !sfr_rdata[6];
	endproperty
	a_git_rsv: assert property (p_git_rsv) else $error("reserved flag bit set");
	property p_image;
		git |=> sfr_rdata[7] == $past(can_irq_request);
	endproperty
	a_image: assert property (p_image) else $error("irq image differs");
	property p_hold;
		!sfr_rd |=> $stable(sfr_rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved without read");
	property p_bus_off_state;
		bus_off_state |-> !error_passive_state;
	endproperty
	a_bus_off_state: assert property (p_bus_off_state) else $error("bus off and passive together");
endmodule

`default_nettype wire

// *** sim/cgs_bus_node.sv ***
// bus node model: serialises a pattern, lsb first, as sampled bus bits
`timescale 1ns/1ns
`default_nettype none

module cgs_bus_node
(
	// command from the bench
	input wire logic        sys_clk,
	input wire logic        send_req,
	input wire logic [4:0]  send_len,
	input wire logic [15:0] send_bits,
	output logic            send_done,
	// sampled bits
	output logic            bit_strobe,
	output logic            bit_value
);
	logic [4:0] pos_r;
	logic       ph_r;

	////////////////////////////////////////////////////////////////////////////
	// one bit every two clocks; idle bus is recessive, as the wired-and level
	always @(negedge sys_clk)
	begin
		if (!send_req)
		begin
			send_done <= 1'b0;
			pos_r <= 5'h00;
			ph_r <= 1'b0;
			bit_strobe <= 1'b0;
			bit_value <= 1'b1;
		end
		else if (!send_done)
		begin
			ph_r <= !ph_r;
			bit_strobe <= !ph_r;
			if (!ph_r)
				bit_value <= send_bits[pos_r[3:0]];
			else if (pos_r == send_len - 5'h01)
				send_done <= 1'b1;
			else
				pos_r <= pos_r + 5'h01;
		end
	end
endmodule

`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the global status block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic        sys_clk, resetn, sfr_wr, sfr_rd, enable_cmd, rx_buffer_full;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
	logic        tx_frame_active, tx_ack_active, tx_frame_pending, ifs_active;
	logic        overload_tx_active, rx_frame_active, timer_overrun_irq_enable;
	logic [15:0] can_timer_value, send_bits, fb;
	logic        bit_strobe, bit_value, stuff_check_en, crc_init, crc_check;
	logic        fixed_form_check, ack_slot_check, tec_inc, tec_dec, rec_inc_small;
	logic        rec_inc_big, rec_dec, recovery_seq_seen, rx_irq_req, tx_irq_req;
	logic        object_error_irq_req, can_irq_request, bus_off_state;
	logic        error_passive_state, send_req, send_done;
	logic [1:0]  crc_mode;
	logic [4:0]  send_len;
	logic [14:0] c;
	logic [5:0]  sv [6] = '{6'h20, 6'h10, 6'h08, 6'h06, 6'h04, 6'h01};
	logic [7:0]  se [6] = '{8'h40, 8'h10, 8'h10, 8'h10, 8'h00, 8'h08};
	int          fail_count, num_checks;

	////////////////////////////////////////////////////////////////////////////
	cgs_global_status uut (.sys_clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
		.sfr_rdata, .tx_frame_active, .tx_ack_active, .tx_frame_pending, .ifs_active,
		.overload_tx_active, .rx_frame_active, .enable_cmd, .can_timer_value,
		.rx_buffer_full, .timer_overrun_irq_enable, .bit_strobe, .bit_value,
		.stuff_check_en, .crc_init, .crc_data_bit_valid(bit_strobe && crc_mode == 2'h1),
		.crc_field_bit_valid(bit_strobe && crc_mode == 2'h2), .crc_check,
		.fixed_form_check, .ack_slot_check, .tec_inc, .tec_dec, .rec_inc_small,
		.rec_inc_big, .rec_dec, .recovery_seq_seen, .rx_irq_req, .tx_irq_req,
		.object_error_irq_req, .can_irq_request, .bus_off_state, .error_passive_state);
	cgs_bus_node u_node (.sys_clk, .send_req, .send_len, .send_bits, .send_done,
		.bit_strobe, .bit_value);

	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = !sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr = a;
		sfr_rd = 1'b1;
		cyc(1);
		sfr_rd = 1'b0;
		chk(sfr_rdata, exp);
		cyc(1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		cyc(1);
		sfr_wr = 1'b0;
		cyc(1);
	endtask
	task automatic irq(input logic exp);
		chk({7'h00, can_irq_request}, {7'h00, exp});
	endtask
	// counter events: {tec+8, tec-1, rec+1, rec+8, rec-1, recovery}
	task automatic ev(input logic [5:0] e, input int n);
		{tec_inc, tec_dec, rec_inc_small, rec_inc_big, rec_dec, recovery_seq_seen} = e;
		cyc(n);
		{tec_inc, tec_dec, rec_inc_small, rec_inc_big, rec_dec, recovery_seq_seen} = 6'h00;
		cyc(2);
	endtask
	// the node model needs its request changed by nonblocking assignment
	task automatic send(input logic [4:0] n, input logic [15:0] b);
		send_len = n;
		send_bits = b;
		send_req <= 1'b1;
		for (int i = 0; i < 100 && !send_done; i++)
			cyc(1);
		if (!send_done)
		begin
			fail_count++;
			complete_run();
		end
		send_req <= 1'b0;
		cyc(2);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{resetn, sfr_wr, sfr_rd, enable_cmd, rx_buffer_full, tx_frame_active} = 6'h00;
		{tx_ack_active, tx_frame_pending, ifs_active, overload_tx_active} = 4'h0;
		{rx_frame_active, timer_overrun_irq_enable, stuff_check_en, crc_init} = 4'h0;
		{crc_check, fixed_form_check, ack_slot_check, send_req} = 4'h0;
		{rx_irq_req, tx_irq_req, object_error_irq_req} = 3'h0;
		{tec_inc, tec_dec, rec_inc_small, rec_inc_big, rec_dec, recovery_seq_seen} = 6'h00;
		{sfr_addr, sfr_wdata, can_timer_value, send_bits} = 48'h0;
		{crc_mode, send_len, fail_count, num_checks} = '0;
		cyc(4);
		resetn = 1'b1;
		rd(8'h9B, 8'h00);
		rd(8'h9C, 8'h00);
		rd(8'h9D, 8'h00);
		rd(8'hC1, 8'h00);
		rd(8'h50, 8'h00);
		wr(8'h9C, 8'h55);
		rd(8'h9C, 8'h00);
		wr(8'hC1, 8'h3E);
		rd(8'hC1, 8'h3E);
		wr(8'hC1, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 6; i++)
		begin
			{overload_tx_active, tx_frame_active, tx_ack_active, tx_frame_pending,
				ifs_active, rx_frame_active} = sv[i];
			cyc(2);
			rd(8'hAA, se[i]);
			irq(1'b0);
		end
		rx_frame_active = 1'b0;
		enable_cmd = 1'b1;
		rd(8'hAA, 8'h08);
		cyc(3);
		rd(8'hAA, 8'h04);
		{rx_frame_active, enable_cmd} = 2'h2;
		cyc(3);
		rd(8'hAA, 8'h0C);
		rx_frame_active = 1'b0;
		cyc(3);
		rd(8'hAA, 8'h00);
		irq(1'b0);
		$display("test status done");
		can_timer_value = 16'hFFFF;
		cyc(1);
		can_timer_value = 16'h0000;
		cyc(3);
		irq(1'b0);
		wr(8'h9B, 8'hBF);
		rd(8'h9B, 8'h20);
		timer_overrun_irq_enable = 1'b1;
		cyc(2);
		rd(8'h9B, 8'hA0);
		wr(8'h9B, 8'h9F);
		cyc(2);
		rd(8'h9B, 8'h00);
		wr(8'hC1, 8'h04);
		rx_buffer_full = 1'b1;
		cyc(3);
		irq(1'b1);
		rx_buffer_full = 1'b0;
		cyc(2);
		rd(8'h9B, 8'h90);
		wr(8'h9B, 8'hAF);
		cyc(2);
		rd(8'h9B, 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			{rx_irq_req, tx_irq_req, object_error_irq_req} = 3'h4 >> i;
			wr(8'hC1, 8'h00);
			cyc(2);
			irq(1'b0);
			wr(8'hC1, 8'h20 >> i);
			cyc(1);
			irq(1'b1);
		end
		{rx_irq_req, tx_irq_req, object_error_irq_req} = 3'h0;
		$display("test interrupts done");
		wr(8'hC1, 8'h02);
		stuff_check_en = 1'b1;
		send(5'd6, 16'h0020);
		rd(8'h9B, 8'h00);
		stuff_check_en = 1'b0;
		cyc(1);
		stuff_check_en = 1'b1;
		send(5'd6, 16'h0000);
		stuff_check_en = 1'b0;
		cyc(2);
		rd(8'h9B, 8'h88);
		wr(8'h9B, 8'hB7);
		{fixed_form_check, ack_slot_check} = 2'h2;
		send(5'd1, 16'h0001);
		{fixed_form_check, ack_slot_check} = 2'h1;
		send(5'd1, 16'h0000);
		rd(8'h9B, 8'h00);
		{fixed_form_check, ack_slot_check} = 2'h2;
		send(5'd1, 16'h0000);
		{fixed_form_check, ack_slot_check} = 2'h1;
		send(5'd1, 16'h0001);
		ack_slot_check = 1'b0;
		cyc(2);
		rd(8'h9B, 8'h83);
		wr(8'h9B, 8'hBC);
		$display("test bit errors done");
		// reference crc over 0xA5, lsb first, then sent back msb first
		c = 15'h0000;
		for (int k = 0; k < 8; k++)
			c = {c[13:0], 1'b0} ^ ((c[14] ^ 8'hA5 >> k & 1'b1) ? 15'h4599 : 15'h0000);
		for (int k = 0; k < 15; k++)
			fb[k] = c[14 - k];
		for (int i = 0; i < 2; i++)
		begin
			crc_init = 1'b1;
			cyc(1);
			{crc_init, crc_mode} = 3'h1;
			send(5'd8, 16'h00A5);
			crc_mode = 2'h2;
			send(5'd15, {1'b0, fb[14:1], fb[0] ^ i[0]});
			{crc_mode, crc_check} = 3'h1;
			cyc(1);
			crc_check = 1'b0;
			cyc(2);
			rd(8'h9B, i[0] ? 8'h84 : 8'h00);
		end
		$display("test crc done");
		ev(6'h20, 15);
		rd(8'h9C, 8'h78);
		chk({6'h00, bus_off_state, error_passive_state}, 8'h00);
		ev(6'h20, 1);
		chk({6'h00, bus_off_state, error_passive_state}, 8'h01);
		ev(6'h20, 16);
		chk({6'h00, bus_off_state, error_passive_state}, 8'h02);
		rd(8'h9C, 8'hFF);
		ev(6'h01, 127);
		chk({6'h00, bus_off_state, error_passive_state}, 8'h02);
		ev(6'h01, 1);
		chk({6'h00, bus_off_state, error_passive_state}, 8'h00);
		ev(6'h10, 1);
		rd(8'h9C, 8'h00);
		ev(6'h04, 16);
		rd(8'h9D, 8'h80);
		chk({6'h00, bus_off_state, error_passive_state}, 8'h01);
		ev(6'h02, 1);
		rd(8'h9D, 8'h7F);
		ev(6'h08, 1);
		rd(8'h9D, 8'h80);
		$display("test counters done");
		complete_run();
	end

	initial
	begin
		repeat (40000) @(posedge sys_clk);
		fail_count++;
		complete_run();
	end
endmodule

bind cgs_global_status cgs_properties u_prop (.sys_clk, .resetn, .sfr_addr, .sfr_rd,
	.sfr_rdata, .tx_frame_active, .tx_ack_active, .tx_frame_pending, .ifs_active,
	.overload_tx_active, .rx_frame_active, .can_irq_request, .bus_off_state,
	.error_passive_state);

`default_nettype wire
